// File: design/tpc_map.svh
// Register offsets, field positions, reset values and widths of the position capture block.
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

`define TPC_CTRL_OFFSET 16'h1b74
`define TPC_STAT_OFFSET 16'h1b76
`define TPC_CTRL_RESET 16'h0000
`define TPC_CTRL_MASK 16'h3333
`define TPC_CTRL_ACT_BIT 0
`define TPC_CTRL_CONT_BIT 1
`define TPC_CTRL_RISE_BIT 4
`define TPC_CTRL_FALL_BIT 5
`define TPC_STAT_ACT_BIT 0
`define TPC_STAT_RISE_BIT 1
`define TPC_STAT_FALL_BIT 2
`define TPC_CH_STRIDE 8
`define TPC_POS_W 32
`define TPC_CNT_W 16
`define TPC_HWREV_TWO_INPUTS 1'b1

`endif

// File: design/tpc_pkg.sv
// Types shared by the position capture block.
package tpc_pkg;
    typedef logic [31:0] tpc_pos_t;
    typedef logic [15:0] tpc_cnt_t;
    typedef logic [15:0] tpc_word_t;
    typedef enum logic [1:0] {
        TPC_IDLE,
        TPC_ARMED,
        TPC_DONE
    } tpc_state_t;
endpackage

// File: design/tpc_channel.sv
// One capture channel: pin synchroniser, edge detection, captured positions and counters.
`timescale 1ns/1ps
`include "tpc_map.svh"

module tpc_channel
    import tpc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Channel control.
    input wire logic i_present,
    input wire logic i_active,
    input wire logic i_cont,
    input wire logic i_rise_en,
    input wire logic i_fall_en,
    input wire logic i_one_edge,
    // Pin and position.
    input wire logic i_pin,
    input wire tpc_pos_t i_pos,
    input wire logic i_pos_shift,
    input wire tpc_pos_t i_pos_delta,
    // Results.
    output logic o_active,
    output logic o_rise_flag,
    output logic o_fall_flag,
    output tpc_pos_t o_rise_pos,
    output tpc_pos_t o_fall_pos,
    output tpc_cnt_t o_rise_cnt,
    output tpc_cnt_t o_fall_cnt
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic act_d_r;
    tpc_state_t state_r;
    logic en;
    logic arm;
    logic rise_ev;
    logic fall_ev;
    logic fall_ok;
    logic take;

    // Three stage pin synchroniser; level moves only when stages two and three agree.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r) begin
                level_r <= sync3_r;
            end
        end
    end

    // Edges come from comparing the agreed stage-three sample with the filtered level it is about to replace.
    assign en = i_present & i_active;
    assign arm = en & ~act_d_r;
    assign rise_ev = sync3_r & ~level_r & (sync2_r == sync3_r) & i_rise_en;
    // With single-edge polarity a set rising bit wins over the falling bit.
    assign fall_ok = i_fall_en & ~(i_one_edge & i_rise_en);
    assign fall_ev = ~sync3_r & level_r & (sync2_r == sync3_r) & fall_ok;
    assign take = (state_r == TPC_ARMED) & ~arm;

    // Arming state: one-time capture stops after its first qualifying edge.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= TPC_IDLE;
            act_d_r <= 1'b0;
        end else begin
            act_d_r <= en;
            case (state_r)
                TPC_IDLE: begin
                    if (en) begin
                        state_r <= TPC_ARMED;
                    end
                end
                TPC_ARMED: begin
                    if (!en) begin
                        state_r <= TPC_IDLE;
                    end else if (take && (rise_ev || fall_ev) && !i_cont) begin
                        state_r <= TPC_DONE;
                    end
                end
                TPC_DONE: begin
                    if (!en) begin
                        state_r <= TPC_IDLE;
                    end else if (i_cont) begin
                        state_r <= TPC_ARMED;
                    end
                end
                default: begin
                    state_r <= TPC_IDLE;
                end
            endcase
        end
    end

    // Flags and counters clear on activation, before any edge is taken.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_active <= 1'b0;
            o_rise_flag <= 1'b0;
            o_fall_flag <= 1'b0;
            o_rise_cnt <= '0;
            o_fall_cnt <= '0;
        end else begin
            o_active <= en;
            if (arm) begin
                o_rise_flag <= 1'b0;
                o_fall_flag <= 1'b0;
                o_rise_cnt <= '0;
                o_fall_cnt <= '0;
            end else if (take) begin
                if (rise_ev) begin
                    o_rise_flag <= 1'b1;
                    o_rise_cnt <= o_rise_cnt + 16'h0001;
                end
                if (fall_ev) begin
                    o_fall_flag <= 1'b1;
                    o_fall_cnt <= o_fall_cnt + 16'h0001;
                end
            end
        end
    end

    // Captured positions; a reference shift moves stored values with the new origin.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rise_pos <= '0;
            o_fall_pos <= '0;
        end else begin
            if (take && rise_ev) begin
                o_rise_pos <= i_pos;
            end else if (i_pos_shift) begin
                o_rise_pos <= o_rise_pos + i_pos_delta;
            end
            if (take && fall_ev) begin
                o_fall_pos <= i_pos;
            end else if (i_pos_shift) begin
                o_fall_pos <= o_fall_pos + i_pos_delta;
            end
        end
    end

endmodule

// File: design/tpc_capture.sv
// Top of the position capture block: control and status words and two channels.
`timescale 1ns/1ps
`include "tpc_map.svh"

module tpc_capture
    import tpc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Hardware revision strap, high when the second input exists.
    input wire logic i_hw_two_inputs,
    // Parameter access port.
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire tpc_word_t i_wdata,
    output tpc_word_t o_rdata,
    output logic o_rvalid,
    output logic o_err,
    // Capture pins.
    input wire logic i_first_capture_pin,
    input wire logic i_second_capture_pin,
    // Motor position and reference redefinition.
    input wire tpc_pos_t i_motor_pos,
    input wire logic i_pos_shift,
    input wire tpc_pos_t i_pos_delta,
    // Captured results.
    output tpc_pos_t o_in1_rising_position,
    output tpc_pos_t o_in1_falling_position,
    output tpc_cnt_t o_in1_rising_event_count,
    output tpc_cnt_t o_in1_falling_event_count,
    output tpc_pos_t o_in2_rising_position,
    output tpc_pos_t o_in2_falling_position,
    output tpc_cnt_t o_in2_rising_event_count,
    output tpc_cnt_t o_in2_falling_event_count
);

    tpc_word_t probe_control_word_r;
    tpc_word_t probe_status_word;
    logic strap_done_r;
    logic two_inputs_r;
    logic [1:0] act;
    logic [1:0] rflag;
    logic [1:0] fflag;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture: the revision level is sampled once after reset release.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_done_r <= 1'b0;
            two_inputs_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            two_inputs_r <= i_hw_two_inputs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control word: reserved bits are stored as zero, so a careless host sees no effect.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            probe_control_word_r <= `TPC_CTRL_RESET;
        end else if (i_wr && i_addr == `TPC_CTRL_OFFSET) begin
            probe_control_word_r <= i_wdata & `TPC_CTRL_MASK;
        end
    end

    // Status word assembled from the channel registers.
    always_comb begin
        probe_status_word = '0;
        probe_status_word[`TPC_STAT_ACT_BIT] = act[0];
        probe_status_word[`TPC_STAT_RISE_BIT] = rflag[0];
        probe_status_word[`TPC_STAT_FALL_BIT] = fflag[0];
        probe_status_word[`TPC_CH_STRIDE + `TPC_STAT_ACT_BIT] = act[1];
        probe_status_word[`TPC_CH_STRIDE + `TPC_STAT_RISE_BIT] = rflag[1];
        probe_status_word[`TPC_CH_STRIDE + `TPC_STAT_FALL_BIT] = fflag[1];
    end

    // Read answers one cycle after the strobe; an unknown address reads zero with error.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
            o_err <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            o_err <= (i_rd || i_wr) && i_addr != `TPC_CTRL_OFFSET
                && !(i_rd && i_addr == `TPC_STAT_OFFSET);
            if (i_rd && i_addr == `TPC_CTRL_OFFSET) begin
                o_rdata <= probe_control_word_r;
            end else if (i_rd && i_addr == `TPC_STAT_OFFSET) begin
                o_rdata <= probe_status_word;
            end else if (i_rd) begin
                o_rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // First input, always fitted.
    tpc_channel u_ch1 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_present(1'b1),
        .i_active(probe_control_word_r[`TPC_CTRL_ACT_BIT]),
        .i_cont(probe_control_word_r[`TPC_CTRL_CONT_BIT]),
        .i_rise_en(probe_control_word_r[`TPC_CTRL_RISE_BIT]),
        .i_fall_en(probe_control_word_r[`TPC_CTRL_FALL_BIT]),
        .i_one_edge(1'b0),
        .i_pin(i_first_capture_pin),
        .i_pos(i_motor_pos),
        .i_pos_shift(i_pos_shift),
        .i_pos_delta(i_pos_delta),
        .o_active(act[0]),
        .o_rise_flag(rflag[0]),
        .o_fall_flag(fflag[0]),
        .o_rise_pos(o_in1_rising_position),
        .o_fall_pos(o_in1_falling_position),
        .o_rise_cnt(o_in1_rising_event_count),
        .o_fall_cnt(o_in1_falling_event_count)
    );

    // Second input, present only on the newer revision, single polarity.
    tpc_channel u_ch2 (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_present(two_inputs_r),
        .i_active(probe_control_word_r[`TPC_CH_STRIDE + `TPC_CTRL_ACT_BIT]),
        .i_cont(probe_control_word_r[`TPC_CH_STRIDE + `TPC_CTRL_CONT_BIT]),
        .i_rise_en(probe_control_word_r[`TPC_CH_STRIDE + `TPC_CTRL_RISE_BIT]),
        .i_fall_en(probe_control_word_r[`TPC_CH_STRIDE + `TPC_CTRL_FALL_BIT]),
        .i_one_edge(1'b1),
        .i_pin(i_second_capture_pin),
        .i_pos(i_motor_pos),
        .i_pos_shift(i_pos_shift),
        .i_pos_delta(i_pos_delta),
        .o_active(act[1]),
        .o_rise_flag(rflag[1]),
        .o_fall_flag(fflag[1]),
        .o_rise_pos(o_in2_rising_position),
        .o_fall_pos(o_in2_falling_position),
        .o_rise_cnt(o_in2_rising_event_count),
        .o_fall_cnt(o_in2_falling_event_count)
    );

endmodule

// File: sim/tpc_capture_checker.sv
// Concurrent checks on the ports of the position capture block.
`timescale 1ns/1ps
`include "tpc_map.svh"

module tpc_capture_checker
    import tpc_pkg::*;
(
    // Clock, reset and strap.
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_hw_two_inputs,
    // Register access.
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire tpc_word_t i_wdata,
    input wire tpc_word_t o_rdata,
    input wire logic o_rvalid,
    input wire logic o_err,
    // Position.
    input wire tpc_pos_t i_motor_pos,
    input wire logic i_pos_shift,
    input wire tpc_pos_t i_pos_delta,
    // Results.
    input wire tpc_pos_t o_in1_rising_position,
    input wire tpc_pos_t o_in1_falling_position,
    input wire tpc_cnt_t o_in1_rising_event_count,
    input wire tpc_cnt_t o_in1_falling_event_count,
    input wire tpc_cnt_t o_in2_rising_event_count,
    input wire tpc_cnt_t o_in2_falling_event_count
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    tpc_word_t ctl_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control word, so activation can be told from a rewrite.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_r <= 16'h0000;
        end else if (i_wr && i_addr == `TPC_CTRL_OFFSET) begin
            ctl_r <= i_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_ack;
        i_rd && !i_wr && (i_addr == `TPC_CTRL_OFFSET || i_addr == `TPC_STAT_OFFSET)
            |=> o_rvalid && !o_err;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_wr_now;
        i_rd && i_addr == `TPC_CTRL_OFFSET |=> o_rdata == ($past(ctl_r) & 16'h3333);
    endproperty
    a_wr_now: assert property (p_wr_now) else $error("control readback wrong");
    property p_act_clr;
        i_wr && i_addr == `TPC_CTRL_OFFSET && i_wdata[0] && !ctl_r[0]
            |-> ##2 o_in1_rising_event_count == 16'h0000 && o_in1_falling_event_count == 16'h0000;
    endproperty
    a_act_clr: assert property (p_act_clr) else $error("counters not cleared");
    property p_rise_pos;
        $changed(o_in1_rising_event_count) && o_in1_rising_event_count != 16'h0000
            |-> o_in1_rising_position == $past(i_motor_pos);
    endproperty
    a_rise_pos: assert property (p_rise_pos) else $error("rising position wrong");
    property p_fall_pos;
        $changed(o_in1_falling_event_count) && o_in1_falling_event_count != 16'h0000
            |-> o_in1_falling_position == $past(i_motor_pos);
    endproperty
    a_fall_pos: assert property (p_fall_pos) else $error("falling position wrong");
    property p_cnt_step;
        $changed(o_in1_rising_event_count) |-> o_in1_rising_event_count == 16'h0000
            || o_in1_rising_event_count == $past(o_in1_rising_event_count) + 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
    property p_shift;
        $past(i_pos_shift) && !$changed(o_in1_rising_event_count)
            |-> o_in1_rising_position == $past(o_in1_rising_position) + $past(i_pos_delta);
    endproperty
    a_shift: assert property (p_shift) else $error("position not shifted");
    property p_strap;
        !i_hw_two_inputs |-> o_in2_rising_event_count == 16'h0000
            && o_in2_falling_event_count == 16'h0000;
    endproperty
    a_strap: assert property (p_strap) else $error("missing input captured");
endmodule

bind tpc_capture tpc_capture_checker tpc_capture_checker_i (.i_clk, .i_resetn,
    .i_hw_two_inputs, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rvalid, .o_err,
    .i_motor_pos, .i_pos_shift, .i_pos_delta, .o_in1_rising_position,
    .o_in1_falling_position, .o_in1_rising_event_count, .o_in1_falling_event_count,
    .o_in2_rising_event_count, .o_in2_falling_event_count);

// File: sim/tpc_sensor.sv
// Switch model that drives the two capture pins.
`timescale 1ns/1ps

module tpc_sensor (
    // Clock.
    input wire logic i_clk,
    // Pins.
    output logic o_pin1,
    output logic o_pin2
);
    // Pins rest low, as a switch with a pull-down does.
    initial begin
        o_pin1 = 1'b0;
        o_pin2 = 1'b0;
    end
    // Levels are held six clocks so the synchroniser cannot miss either edge.
    task automatic pulse(input logic ch);
        @(posedge i_clk);
        #1;
        if (ch) begin
            o_pin2 = 1'b1;
        end else begin
            o_pin1 = 1'b1;
        end
        repeat (6) @(posedge i_clk);
        #1;
        o_pin1 = 1'b0;
        o_pin2 = 1'b0;
        repeat (6) @(posedge i_clk);
        // Return off the edge, so the caller never samples in the launching time step.
        #1;
    endtask
endmodule

// File: sim/tpc_capture_tb.sv
// Self-checking bench for the position capture block.
`timescale 1ns/1ps
`include "tpc_map.svh"

module tpc_capture_tb
    import tpc_pkg::*;
();
    localparam logic [15:0] ctl_a = `TPC_CTRL_OFFSET;
    localparam logic [15:0] st_a = `TPC_STAT_OFFSET;
    logic i_clk, i_resetn, i_hw_two_inputs, i_wr, i_rd, i_pos_shift, o_rvalid, o_err;
    logic i_first_capture_pin, i_second_capture_pin;
    logic [15:0] i_addr;
    tpc_word_t i_wdata, o_rdata;
    tpc_pos_t i_motor_pos, i_pos_delta, o_in1_rising_position, o_in1_falling_position;
    tpc_pos_t o_in2_rising_position, o_in2_falling_position;
    tpc_cnt_t o_in1_rising_event_count, o_in1_falling_event_count;
    tpc_cnt_t o_in2_rising_event_count, o_in2_falling_event_count;
    int fail_count = 0;
    int checks = 0;
    tpc_capture tpc_capture_i (.i_clk, .i_resetn, .i_hw_two_inputs, .i_addr, .i_wr, .i_rd,
        .i_wdata, .o_rdata, .o_rvalid, .o_err, .i_first_capture_pin, .i_second_capture_pin,
        .i_motor_pos, .i_pos_shift, .i_pos_delta, .o_in1_rising_position,
        .o_in1_falling_position, .o_in1_rising_event_count, .o_in1_falling_event_count,
        .o_in2_rising_position, .o_in2_falling_position, .o_in2_rising_event_count,
        .o_in2_falling_event_count);
    tpc_sensor tpc_sensor_i (.i_clk, .o_pin1(i_first_capture_pin), .o_pin2(i_second_capture_pin));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 125 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Writes carry no acknowledge, so the strobe is simply one clock wide.
    task automatic reg_wr(input logic [15:0] a, input tpc_word_t d);
        @(posedge i_clk);
        #1;
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(posedge i_clk);
        #1;
        i_wr = 1'b0;
    endtask
    // The answer stands for one clock only, so it is looked at just after that edge.
    task automatic reg_rd(input logic [15:0] a, input tpc_word_t exp, input logic bad);
        repeat (2) @(posedge i_clk);
        #1;
        i_addr = a;
        i_rd = 1'b1;
        @(posedge i_clk);
        #1;
        i_rd = 1'b0;
        // Every read is answered; an unmapped one returns zero with the error pulse.
        chk("rvalid", o_rvalid, 1'b1);
        chk("err", o_err, bad);
        chk("rdata", o_rdata, exp);
    endtask
    task automatic do_reset(input logic two);
        i_resetn = 1'b0;
        i_hw_two_inputs = two;
        repeat (3) @(posedge i_clk);
        #1;
        i_resetn = 1'b1;
    endtask
    // Motor position seen by the block; it only changes while the pins are quiet.
    task automatic set_pos(input tpc_pos_t p);
        i_motor_pos = p;
    endtask
    // One-cycle reference redefinition, then one settling clock.
    task automatic shift_ref(input tpc_pos_t d);
        @(posedge i_clk);
        #1;
        i_pos_delta = d;
        i_pos_shift = 1'b1;
        @(posedge i_clk);
        #1;
        i_pos_shift = 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {i_wr, i_rd, i_pos_shift, i_addr, i_wdata, i_pos_delta} = '0;
        set_pos(32'h1234_5678);
        do_reset(1'b1);
        reg_rd(ctl_a, 16'h0000, 1'b0);
        reg_rd(16'h1b78, 16'h0000, 1'b1);
        // The host keeps reserved bits zero and never sets both edges on input two.
        reg_wr(ctl_a, 16'h1333);
        reg_rd(ctl_a, 16'h1333, 1'b0);
        reg_wr(ctl_a, 16'h0000);
        reg_wr(st_a, 16'h0001);
        reg_rd(st_a, 16'h0000, 1'b0);
        reg_wr(ctl_a, 16'h0011);
        reg_rd(st_a, 16'h0001, 1'b0);
        tpc_sensor_i.pulse(1'b0);
        set_pos(32'h0000_0abc);
        tpc_sensor_i.pulse(1'b0);
        chk("r1c", o_in1_rising_event_count, 32'h1);
        chk("r1p", o_in1_rising_position, 32'h1234_5678);
        chk("f1c", o_in1_falling_event_count, 32'h0);
        reg_rd(st_a, 16'h0003, 1'b0);
        shift_ref(32'h0000_0100);
        chk("r1p", o_in1_rising_position, 32'h1234_5778);
        reg_wr(ctl_a, 16'h0000);
        reg_wr(ctl_a, 16'h0033);
        reg_rd(st_a, 16'h0001, 1'b0);
        chk("r1c", o_in1_rising_event_count, 32'h0);
        tpc_sensor_i.pulse(1'b0);
        set_pos(32'h0000_0def);
        tpc_sensor_i.pulse(1'b0);
        chk("r1c", o_in1_rising_event_count, 32'h2);
        chk("r1p", o_in1_rising_position, 32'h0000_0def);
        chk("f1c", o_in1_falling_event_count, 32'h2);
        chk("f1p", o_in1_falling_position, 32'h0000_0def);
        reg_rd(st_a, 16'h0007, 1'b0);
        // Input one keeps its captured flags while deactivated.
        reg_wr(ctl_a, 16'h1300);
        tpc_sensor_i.pulse(1'b1);
        chk("r2c", o_in2_rising_event_count, 32'h1);
        chk("r2p", o_in2_rising_position, 32'h0000_0def);
        chk("f2c", o_in2_falling_event_count, 32'h0);
        reg_rd(st_a, 16'h0306, 1'b0);
        reg_wr(ctl_a, 16'h0000);
        reg_wr(ctl_a, 16'h2100);
        tpc_sensor_i.pulse(1'b1);
        chk("f2c", o_in2_falling_event_count, 32'h1);
        chk("f2p", o_in2_falling_position, 32'h0000_0def);
        chk("r2c", o_in2_rising_event_count, 32'h0);
        reg_rd(st_a, 16'h0506, 1'b0);
        do_reset(1'b0);
        reg_wr(ctl_a, 16'h1100);
        tpc_sensor_i.pulse(1'b1);
        chk("r2c", o_in2_rising_event_count, 32'h0);
        reg_rd(st_a, 16'h0000, 1'b0);
        final_report();
    end
endmodule
